// ---- dv/iop_pin_model.sv ----
// external circuitry on eight pins: drivers, pull-ups, floating lines
`timescale 1ns/1ps
module iop_pin_model (
  input wire logic pclk,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pad_pu_en,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin
);
  logic [7:0] last_r = 8'h00;
  always_ff @(posedge pclk) begin
    last_r <= pin;
  end
  // a floating pin toggles so a stale level never reads as valid
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] : pad_pu_en[i] ? 1'b1 : ~last_r[i];
    end
  end
endmodule : iop_pin_model

// ---- dv/iop_port_sva.sv ----
// concurrent checks on the i/o port block pins
`timescale 1ns/1ps
module iop_port_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic card_io_supply_rail,
  input wire logic [iop_pkg::IOP_W-1:0] pa_pad_out,
  input wire logic [iop_pkg::IOP_W-1:0] pa_pad_oe,
  input wire logic [iop_pkg::IOP_W-1:0] pa_pad_pu_en,
  input wire logic [iop_pkg::IOP_W-1:0] pa_pad_hs_en,
  input wire logic [iop_pkg::IOP_W-1:0] second_port_pins_out,
  input wire logic [iop_pkg::IOP_W-1:0] second_port_pins_oe,
  input wire logic [iop_pkg::IOP_W-1:0] second_port_pins_pu_en,
  input wire logic [iop_pkg::IOP_W-1:0] second_port_pins_hs_en,
  input wire logic [iop_pkg::IOP_W-1:0] pa_alt_ie,
  input wire logic [iop_pkg::IOP_W-1:0] pa_alt_in
);
  // ****************************************************************
  // bus timing
  // ****************************************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready_after_setup;
    psel && !penable |=> pready;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");
  property p_ready_cause;
    pready |-> psel && penable && $past(psel && !penable) ##1 !pready;
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready without setup");
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("slave error without ready");
  // ****************************************************************
  // pad rules
  // ****************************************************************
  // sync plus register lag, so five samples of a missing rail
  property p_rail_a;
    !card_io_supply_rail [*5] |-> pa_pad_oe[3:0] == 4'hF && (pa_pad_out[3:0] | pa_pad_hs_en[3:0]) == 4'h0;
  endproperty
  a_rail_a: assert property (p_rail_a) else $error("port a rail pin not grounded");
  property p_rail_b;
    !card_io_supply_rail [*5] |-> second_port_pins_oe[7:4] == 4'hF && second_port_pins_out[7:4] == 4'h0;
  endproperty
  a_rail_b: assert property (p_rail_b) else $error("port b rail pin not grounded");
  property p_true_od;
    (pa_pad_pu_en[7:6] | pa_pad_hs_en[7:6] | (pa_pad_oe[7:6] & pa_pad_out[7:6])) == 2'h0;
  endproperty
  a_true_od: assert property (p_true_od) else $error("true open-drain pin drives high");
  property p_pad_a;
    ((pa_pad_oe & pa_pad_out & ~pa_pad_hs_en) | (pa_pad_pu_en & pa_pad_oe) | (pa_pad_hs_en & ~pa_pad_oe)) == 8'h00;
  endproperty
  a_pad_a: assert property (p_pad_a) else $error("port a pad controls inconsistent");
  property p_port_b;
    second_port_pins_pu_en == 8'h00 && (second_port_pins_hs_en & ~second_port_pins_oe) == 8'h00;
  endproperty
  a_port_b: assert property (p_port_b) else $error("port b pad controls inconsistent");
  property p_alt_in;
    (pa_alt_in & ~$past(pa_alt_ie)) == 8'h00;
  endproperty
  a_alt_in: assert property (p_alt_in) else $error("peripheral input without request");
endmodule : iop_port_sva

bind iop_port_top iop_port_sva iop_port_sva_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .card_io_supply_rail(card_io_supply_rail), .pa_pad_out(pa_pad_out),
  .pa_pad_oe(pa_pad_oe), .pa_pad_pu_en(pa_pad_pu_en), .pa_pad_hs_en(pa_pad_hs_en),
  .second_port_pins_out(second_port_pins_out), .second_port_pins_oe(second_port_pins_oe),
  .second_port_pins_pu_en(second_port_pins_pu_en), .second_port_pins_hs_en(second_port_pins_hs_en),
  .pa_alt_ie(pa_alt_ie), .pa_alt_in(pa_alt_in));

// ---- dv/tb.sv ----
// self-checking bench for the i/o port block
`timescale 1ns/1ps
module tb;
  import iop_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rail = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, e;
  logic pready, pslverr, irq, err;
  logic [7:0] pa_out, pa_oe, pa_pu, pa_hs, pb_out, pb_oe, pb_pu, pb_hs, pa_pin, pb_pin, pa_ai;
  logic [7:0] a_oe = 8'h00, a_out = 8'h00, a_ie = 8'h00, ev = 8'hFF, bv = 8'h00, d, o, l, p;
  logic [7:0] a_pp = 8'h00, xe = 8'hFF;
  int errors = 0;
  int n_checks = 0;
  always #2.5 pclk = ~pclk;
  iop_port_top iop_port_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .card_io_supply_rail(rail), .pa_pad_in(pa_pin), .pa_pad_out(pa_out), .pa_pad_oe(pa_oe), .pa_pad_pu_en(pa_pu),
    .pa_pad_hs_en(pa_hs), .second_port_pins_in(pb_pin), .second_port_pins_out(pb_out),
    .second_port_pins_oe(pb_oe), .second_port_pins_pu_en(pb_pu), .second_port_pins_hs_en(pb_hs),
    .pa_alt_oe(a_oe), .pa_alt_out(a_out), .pa_alt_pp(a_pp), .pa_alt_ie(a_ie), .pa_alt_in(pa_ai),
    .pb_alt_oe(8'h00), .pb_alt_out(8'h00), .pb_alt_pp(8'h00), .pb_alt_ie(8'h00), .pb_alt_in());
  iop_pin_model pa_model_i (.pclk(pclk), .pad_out(pa_out), .pad_oe(pa_oe), .pad_pu_en(pa_pu), .ext_en(xe),
    .ext_val(ev), .pin(pa_pin));
  iop_pin_model pb_model_i (.pclk(pclk), .pad_out(pb_out), .pad_oe(pb_oe), .pad_pu_en(pb_pu), .ext_en(xe),
    .ext_val(bv), .pin(pb_pin));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 50) begin
      errors++;
      finish_test();
    end
  endtask : apb
  // port a pads with rail up: {oe, driven out, high side, pull-up}
  function automatic logic [31:0] pa_exp(input logic [7:0] dd, input logic [7:0] oo, input logic [7:0] ll,
                                         input logic [7:0] pp);
    logic [7:0] push;
    push = dd & oo & ~IOP_PA_TOD_MASK;
    return {push | (dd & ~push & ~ll), push & ll, push, ~dd & pp & ~IOP_PA_TOD_MASK};
  endfunction : pa_exp
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (100000) @(posedge pclk);
    errors++;
    finish_test();
  end
  initial begin
    d = 8'($urandom(32'h8D00));
    repeat (20) @(posedge pclk);
    chk({pa_oe, pb_oe, pa_out | pa_hs | pa_pu, pb_out | pb_hs | pb_pu}, 32'h0FF00000);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    chk({pa_oe, pb_oe}, 16'h0FF0);
    apb(1'b0, IOP_ADDR_RAIL_CTRL, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, IOP_ADDR_RAIL_CTRL, 32'h3);
    repeat (6) @(posedge pclk);
    chk({pa_oe, pb_oe}, 16'h0000);
    for (int n = 0; n < 10; n++) begin
      d = n == 0 ? 8'hFF : 8'($urandom());
      o = n == 0 ? 8'hFF : 8'($urandom());
      l = 8'($urandom());
      p = 8'($urandom());
      ev <= 8'($urandom());
      apb(1'b1, IOP_ADDR_PA_DATA, {24'h0, l});
      apb(1'b1, IOP_ADDR_PA_DIR, {24'h0, d});
      apb(1'b1, IOP_ADDR_PA_OPT, {24'h0, o});
      apb(1'b1, IOP_ADDR_PA_PULL, {24'h0, p});
      repeat (4) @(posedge pclk);
      e = pa_exp(d, o, l, p);
      chk({pa_oe, pa_out & pa_oe, pa_hs, pa_pu}, e);
      apb(1'b0, IOP_ADDR_PA_DATA, 32'h0);
      chk(rd, {24'h0, (e[31:24] & e[23:16]) | (~e[31:24] & ev)});
      bv <= 8'($urandom());
      apb(1'b1, IOP_ADDR_PB_DATA, {24'h0, l});
      apb(1'b1, IOP_ADDR_PB_DIR, {24'h0, d});
      repeat (4) @(posedge pclk);
      chk({pb_oe, pb_out & pb_oe, pb_hs, pb_pu}, {d, l & d, d, 8'h00});
      apb(1'b0, IOP_ADDR_PB_DATA, 32'h0);
      chk(rd, {24'h0, (l & d) | (bv & ~d)});
    end
    // push-pull alternate output high, open-drain only on true open-drain pin 6, while the line is pulled low outside
    apb(1'b1, IOP_ADDR_PA_DIR, 32'h0);
    ev <= 8'h00;
    a_out <= 8'hFF;
    a_oe <= 8'h5A;
    a_pp <= 8'hFF;
    repeat (4) @(posedge pclk);
    chk({8'h00, pa_oe, pa_out, pa_hs}, 32'h001A1A1A);
    apb(1'b0, IOP_ADDR_PA_DATA, 32'h0);
    chk(rd, 32'h5A);
    a_oe <= 8'h00;
    apb(1'b1, IOP_ADDR_PA_DIR, 32'hFF);
    a_ie <= 8'hFF;
    repeat (3) @(posedge pclk);
    chk(pa_ai, l);
    a_ie <= 8'h00;
    // interrupt enabled while the pin is high, so no spurious event
    ev <= 8'hFF;
    apb(1'b1, IOP_ADDR_PA_DIR, 32'h0);
    apb(1'b1, IOP_ADDR_PA_OPT, 32'h1);
    apb(1'b1, IOP_ADDR_INT_STAT, 32'hFF);
    apb(1'b1, IOP_ADDR_INT_MASK, 32'h1);
    repeat (4) @(posedge pclk);
    chk(irq, 1'b0);
    ev <= 8'hFE;
    repeat (6) @(posedge pclk);
    apb(1'b0, IOP_ADDR_INT_STAT, 32'h0);
    chk(rd, 32'h1);
    chk(irq, 1'b1);
    apb(1'b1, IOP_ADDR_INT_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    apb(1'b1, IOP_ADDR_INT_MASK, 32'h1);
    apb(1'b1, IOP_ADDR_INT_STAT, 32'h1);
    repeat (2) @(posedge pclk);
    apb(1'b0, IOP_ADDR_INT_STAT, 32'h0);
    chk(rd, 32'h0);
    chk(irq, 1'b0);
    apb(1'b0, 12'h040, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    rail <= 1'b0;
    repeat (8) @(posedge pclk);
    chk({pa_oe[3:0], pa_out[3:0], pb_oe[7:4], pb_out[7:4]}, 16'hF0F0);
    // reset mid-run with the rail back: rail pins stay grounded until software enables
    presetn <= 1'b0;
    rail <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({pa_oe, pb_oe, pa_out, pb_out}, 32'h0FF00000);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    chk({pa_oe, pb_oe}, 16'h0FF0);
    finish_test();
  end
endmodule : tb

// ---- verilog/iop_pad_ctl.sv ----
// registered pad control for one eight-pin port
`timescale 1ns/1ps
module iop_pad_ctl #(
  parameter logic HAS_OPT = 1'b1,
  parameter logic [7:0] TOD_MASK = 8'h00,
  parameter logic [7:0] RAIL_MASK = 8'h00
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rail_ok,
  input wire logic [iop_pkg::IOP_W-1:0] dir,
  input wire logic [iop_pkg::IOP_W-1:0] opt,
  input wire logic [iop_pkg::IOP_W-1:0] pull,
  input wire logic [iop_pkg::IOP_W-1:0] latch,
  input wire logic [iop_pkg::IOP_W-1:0] alt_oe,
  input wire logic [iop_pkg::IOP_W-1:0] alt_out,
  input wire logic [iop_pkg::IOP_W-1:0] alt_pp,
  output logic [iop_pkg::IOP_W-1:0] pad_out,
  output logic [iop_pkg::IOP_W-1:0] pad_oe,
  output logic [iop_pkg::IOP_W-1:0] pad_pu_en,
  output logic [iop_pkg::IOP_W-1:0] pad_hs_en
);
  import iop_pkg::*;

  logic [IOP_W-1:0] out_nxt, oe_nxt, pu_nxt, hs_nxt;

  always_comb begin
    iop_mode_t m;
    logic v;
    m = IOP_FLOAT;
    v = 1'b0;
    out_nxt = '0;
    oe_nxt = '0;
    pu_nxt = '0;
    hs_nxt = '0;
    for (int i = 0; i < IOP_W; i++) begin
      m = iop_mode(HAS_OPT, TOD_MASK[i], RAIL_MASK[i] && !rail_ok, dir[i], opt[i], pull[i],
                   alt_oe[i], alt_pp[i]);
      v = alt_oe[i] ? alt_out[i] : latch[i];
      case (m)
        IOP_PULLUP: begin
          pu_nxt[i] = 1'b1;
        end
        IOP_PUSHPULL: begin
          oe_nxt[i] = 1'b1;
          out_nxt[i] = v;
          hs_nxt[i] = 1'b1;
        end
        IOP_OPENDRAIN: begin
          oe_nxt[i] = !v;
        end
        IOP_HELD: begin
          oe_nxt[i] = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // rail pins come out of reset already grounded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out <= 8'h00;
      pad_oe <= RAIL_MASK;
      pad_pu_en <= 8'h00;
      pad_hs_en <= 8'h00;
    end else begin
      pad_out <= out_nxt;
      pad_oe <= oe_nxt;
      pad_pu_en <= pu_nxt & ~TOD_MASK;
      pad_hs_en <= hs_nxt & ~TOD_MASK;
    end
  end

endmodule : iop_pad_ctl

// ---- verilog/iop_pkg.sv ----
// constants, mode type and decode function for the i/o port block
package iop_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int IOP_W = 8;
  localparam int IOP_AW = 12;
  localparam int IOP_SYNC_STAGES = 2;

  // ****************************************************************
  // register byte addresses
  // ****************************************************************
  localparam logic [11:0] IOP_ADDR_PA_DATA = 12'h000;
  localparam logic [11:0] IOP_ADDR_PA_DIR = 12'h004;
  localparam logic [11:0] IOP_ADDR_PA_OPT = 12'h008;
  localparam logic [11:0] IOP_ADDR_PA_PULL = 12'h00C;
  localparam logic [11:0] IOP_ADDR_PB_DATA = 12'h010;
  localparam logic [11:0] IOP_ADDR_PB_DIR = 12'h014;
  localparam logic [11:0] IOP_ADDR_INT_STAT = 12'h018;
  localparam logic [11:0] IOP_ADDR_INT_MASK = 12'h01C;
  localparam logic [11:0] IOP_ADDR_RAIL_CTRL = 12'h020;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int IOP_RAIL_SEL_BIT = 0;
  localparam int IOP_RAIL_EN_BIT = 1;
  localparam int IOP_RAIL_OK_BIT = 2;
  localparam logic [1:0] IOP_RAIL_CTRL_RST = 2'h1;
  localparam logic [7:0] IOP_BYTE_RST = 8'h00;

  // ****************************************************************
  // pin features per port
  // ****************************************************************
  localparam logic [7:0] IOP_PA_TOD_MASK = 8'hC0;
  localparam logic [7:0] IOP_PA_RAIL_MASK = 8'h0F;
  localparam logic [7:0] IOP_PB_TOD_MASK = 8'h00;
  localparam logic [7:0] IOP_PB_RAIL_MASK = 8'hF0;

  typedef enum logic [2:0] {
    IOP_FLOAT,
    IOP_PULLUP,
    IOP_PUSHPULL,
    IOP_OPENDRAIN,
    IOP_HELD
  } iop_mode_t;

  // one pin's effective pad mode from configuration and alternate function
  function automatic iop_mode_t iop_mode(input logic has_opt, input logic tod, input logic held,
                                         input logic dir, input logic opt, input logic pull,
                                         input logic alt_oe, input logic alt_pp);
    iop_mode_t m;
    m = IOP_FLOAT;
    if (held) begin
      m = IOP_HELD;
    end else if (alt_oe) begin
      m = (alt_pp && !tod) ? IOP_PUSHPULL : IOP_OPENDRAIN;
    end else if (!dir) begin
      m = (has_opt && pull && !tod) ? IOP_PULLUP : IOP_FLOAT;
    end else if (!has_opt) begin
      m = IOP_PUSHPULL;
    end else begin
      m = (opt && !tod) ? IOP_PUSHPULL : IOP_OPENDRAIN;
    end
    return m;
  endfunction : iop_mode

endpackage : iop_pkg

// ---- verilog/iop_port_top.sv ----
// two-port gpio block with apb registers, alternate functions and pin interrupts
`timescale 1ns/1ps
module iop_port_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [iop_pkg::IOP_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic card_io_supply_rail,
  input wire logic [iop_pkg::IOP_W-1:0] pa_pad_in,
  output logic [iop_pkg::IOP_W-1:0] pa_pad_out,
  output logic [iop_pkg::IOP_W-1:0] pa_pad_oe,
  output logic [iop_pkg::IOP_W-1:0] pa_pad_pu_en,
  output logic [iop_pkg::IOP_W-1:0] pa_pad_hs_en,
  input wire logic [iop_pkg::IOP_W-1:0] second_port_pins_in,
  output logic [iop_pkg::IOP_W-1:0] second_port_pins_out,
  output logic [iop_pkg::IOP_W-1:0] second_port_pins_oe,
  output logic [iop_pkg::IOP_W-1:0] second_port_pins_pu_en,
  output logic [iop_pkg::IOP_W-1:0] second_port_pins_hs_en,
  input wire logic [iop_pkg::IOP_W-1:0] pa_alt_oe,
  input wire logic [iop_pkg::IOP_W-1:0] pa_alt_out,
  input wire logic [iop_pkg::IOP_W-1:0] pa_alt_pp,
  input wire logic [iop_pkg::IOP_W-1:0] pa_alt_ie,
  output logic [iop_pkg::IOP_W-1:0] pa_alt_in,
  input wire logic [iop_pkg::IOP_W-1:0] pb_alt_oe,
  input wire logic [iop_pkg::IOP_W-1:0] pb_alt_out,
  input wire logic [iop_pkg::IOP_W-1:0] pb_alt_pp,
  input wire logic [iop_pkg::IOP_W-1:0] pb_alt_ie,
  output logic [iop_pkg::IOP_W-1:0] pb_alt_in
);
  import iop_pkg::*;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [IOP_W-1:0] pa_meta_r, pa_sync_r, pb_meta_r, pb_sync_r;
  logic rail_meta_r, rail_sync_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_meta_r <= 8'h00;
      pa_sync_r <= 8'h00;
      pb_meta_r <= 8'h00;
      pb_sync_r <= 8'h00;
      rail_meta_r <= 1'b0;
      rail_sync_r <= 1'b0;
    end else begin
      pa_meta_r <= pa_pad_in;
      pa_sync_r <= pa_meta_r;
      pb_meta_r <= second_port_pins_in;
      pb_sync_r <= pb_meta_r;
      rail_meta_r <= card_io_supply_rail;
      rail_sync_r <= rail_meta_r;
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  logic [IOP_W-1:0] pa_latch_r, pa_latch_nxt, pa_dir_r, pa_dir_nxt;
  logic [IOP_W-1:0] pa_opt_r, pa_opt_nxt, pa_pull_r, pa_pull_nxt;
  logic [IOP_W-1:0] pb_latch_r, pb_latch_nxt, pb_dir_r, pb_dir_nxt;
  logic [IOP_W-1:0] int_stat_r, int_stat_nxt, int_mask_r, int_mask_nxt;
  logic [1:0] rail_ctrl_r, rail_ctrl_nxt;
  logic [IOP_W-1:0] edge_prev_r, edge_prev_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt, irq_nxt;
  logic [IOP_W-1:0] pa_alt_in_nxt, pb_alt_in_nxt;

  logic wr_en, setup;
  logic rail_ok;
  logic [IOP_W-1:0] edge_in, int_event, int_en;
  logic [IOP_W-1:0] pa_read, pb_read;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite && !pslverr;

  // a selected regulator that is still off counts as no rail
  assign rail_ok = rail_sync_r &&
                   !(rail_ctrl_r[IOP_RAIL_SEL_BIT] && !rail_ctrl_r[IOP_RAIL_EN_BIT]);

  // input with interrupt forces the detector to one when disabled,
  // so enabling on a low pin looks like a falling edge
  // per-pin select, so one enabled pin does not arm the whole byte
  assign int_en = ~pa_dir_r & pa_opt_r & ~pa_alt_oe;
  assign edge_in = (int_en & pa_sync_r) | ~int_en;
  assign int_event = edge_prev_r & ~edge_in;

  // ****************************************************************
  // read-back of the data registers
  // ****************************************************************
  // input pins with an alternate output show that output instead of the pad
  function automatic logic [IOP_W-1:0] pin_read(input logic [IOP_W-1:0] dir, input logic [IOP_W-1:0] alt_oe,
                                                input logic [IOP_W-1:0] alt_out, input logic [IOP_W-1:0] pin);
    logic [IOP_W-1:0] show_alt;
    show_alt = ~dir & alt_oe;
    return (show_alt & alt_out) | (~show_alt & pin);
  endfunction : pin_read

  assign pa_read = pin_read(pa_dir_r, pa_alt_oe, pa_alt_out, pa_sync_r);
  assign pb_read = pin_read(pb_dir_r, pb_alt_oe, pb_alt_out, pb_sync_r);

  always_comb begin
    pa_latch_nxt = pa_latch_r;
    pa_dir_nxt = pa_dir_r;
    pa_opt_nxt = pa_opt_r;
    pa_pull_nxt = pa_pull_r;
    pb_latch_nxt = pb_latch_r;
    pb_dir_nxt = pb_dir_r;
    int_mask_nxt = int_mask_r;
    rail_ctrl_nxt = rail_ctrl_r;
    int_stat_nxt = int_stat_r;
    edge_prev_nxt = edge_in;
    if (wr_en) begin
      case (paddr)
        IOP_ADDR_PA_DATA: pa_latch_nxt = pwdata[IOP_W-1:0];
        IOP_ADDR_PA_DIR: pa_dir_nxt = pwdata[IOP_W-1:0];
        IOP_ADDR_PA_OPT: pa_opt_nxt = pwdata[IOP_W-1:0];
        IOP_ADDR_PA_PULL: pa_pull_nxt = pwdata[IOP_W-1:0];
        IOP_ADDR_PB_DATA: pb_latch_nxt = pwdata[IOP_W-1:0];
        IOP_ADDR_PB_DIR: pb_dir_nxt = pwdata[IOP_W-1:0];
        IOP_ADDR_INT_STAT: int_stat_nxt = int_stat_r & ~pwdata[IOP_W-1:0];
        IOP_ADDR_INT_MASK: int_mask_nxt = pwdata[IOP_W-1:0];
        IOP_ADDR_RAIL_CTRL: rail_ctrl_nxt = pwdata[1:0];
        default: begin
        end
      endcase
    end
    // a new event wins over a clear in the same cycle
    int_stat_nxt = int_stat_nxt | int_event;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_latch_r <= IOP_BYTE_RST;
      pa_dir_r <= IOP_BYTE_RST;
      pa_opt_r <= IOP_BYTE_RST;
      pa_pull_r <= IOP_BYTE_RST;
      pb_latch_r <= IOP_BYTE_RST;
      pb_dir_r <= IOP_BYTE_RST;
      int_stat_r <= IOP_BYTE_RST;
      int_mask_r <= IOP_BYTE_RST;
      rail_ctrl_r <= IOP_RAIL_CTRL_RST;
      edge_prev_r <= 8'hFF;
    end else begin
      pa_latch_r <= pa_latch_nxt;
      pa_dir_r <= pa_dir_nxt;
      pa_opt_r <= pa_opt_nxt;
      pa_pull_r <= pa_pull_nxt;
      pb_latch_r <= pb_latch_nxt;
      pb_dir_r <= pb_dir_nxt;
      int_stat_r <= int_stat_nxt;
      int_mask_r <= int_mask_nxt;
      rail_ctrl_r <= rail_ctrl_nxt;
      edge_prev_r <= edge_prev_nxt;
    end
  end

  // ****************************************************************
  // apb answer, one wait-free access phase
  // ****************************************************************
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    pslverr_nxt = 1'b0;
    pready_nxt = setup;
    if (setup) begin
      case (paddr)
        IOP_ADDR_PA_DATA: prdata_nxt[IOP_W-1:0] = pa_read;
        IOP_ADDR_PA_DIR: prdata_nxt[IOP_W-1:0] = pa_dir_r;
        IOP_ADDR_PA_OPT: prdata_nxt[IOP_W-1:0] = pa_opt_r;
        IOP_ADDR_PA_PULL: prdata_nxt[IOP_W-1:0] = pa_pull_r;
        IOP_ADDR_PB_DATA: prdata_nxt[IOP_W-1:0] = pb_read;
        IOP_ADDR_PB_DIR: prdata_nxt[IOP_W-1:0] = pb_dir_r;
        IOP_ADDR_INT_STAT: prdata_nxt[IOP_W-1:0] = int_stat_r;
        IOP_ADDR_INT_MASK: prdata_nxt[IOP_W-1:0] = int_mask_r;
        IOP_ADDR_RAIL_CTRL: begin
          prdata_nxt[1:0] = rail_ctrl_r;
          prdata_nxt[IOP_RAIL_OK_BIT] = rail_ok;
        end
        default: pslverr_nxt = 1'b1;
      endcase
    end
  end

  // ****************************************************************
  // interrupt and alternate inputs
  // ****************************************************************
  // output pins feed the peripheral from the latch, input pins from the pad
  function automatic logic [IOP_W-1:0] alt_feed(input logic [IOP_W-1:0] ie, input logic [IOP_W-1:0] dir,
                                                input logic [IOP_W-1:0] latch, input logic [IOP_W-1:0] pin);
    return ie & ((dir & latch) | (~dir & pin));
  endfunction : alt_feed

  always_comb begin
    irq_nxt = |(int_stat_nxt & int_mask_r);
    pa_alt_in_nxt = alt_feed(pa_alt_ie, pa_dir_r, pa_latch_r, pa_sync_r);
    pb_alt_in_nxt = alt_feed(pb_alt_ie, pb_dir_r, pb_latch_r, pb_sync_r);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
      pa_alt_in <= 8'h00;
      pb_alt_in <= 8'h00;
    end else begin
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
      irq <= irq_nxt;
      pa_alt_in <= pa_alt_in_nxt;
      pb_alt_in <= pb_alt_in_nxt;
    end
  end

  // ****************************************************************
  // pad drivers
  // ****************************************************************
  iop_pad_ctl #(
    .HAS_OPT(1'b1),
    .TOD_MASK(IOP_PA_TOD_MASK),
    .RAIL_MASK(IOP_PA_RAIL_MASK)
  ) u_pad_a (
    .pclk(pclk),
    .presetn(presetn),
    .rail_ok(rail_ok),
    .dir(pa_dir_r),
    .opt(pa_opt_r),
    .pull(pa_pull_r),
    .latch(pa_latch_r),
    .alt_oe(pa_alt_oe),
    .alt_out(pa_alt_out),
    .alt_pp(pa_alt_pp),
    .pad_out(pa_pad_out),
    .pad_oe(pa_pad_oe),
    .pad_pu_en(pa_pad_pu_en),
    .pad_hs_en(pa_pad_hs_en)
  );

  // second port has no option bits: floating in or push-pull out, open-drain only for an alternate output without pb_alt_pp
  iop_pad_ctl #(
    .HAS_OPT(1'b0),
    .TOD_MASK(IOP_PB_TOD_MASK),
    .RAIL_MASK(IOP_PB_RAIL_MASK)
  ) u_pad_b (
    .pclk(pclk),
    .presetn(presetn),
    .rail_ok(rail_ok),
    .dir(pb_dir_r),
    .opt(8'h00),
    .pull(8'h00),
    .latch(pb_latch_r),
    .alt_oe(pb_alt_oe),
    .alt_out(pb_alt_out),
    .alt_pp(pb_alt_pp),
    .pad_out(second_port_pins_out),
    .pad_oe(second_port_pins_oe),
    .pad_pu_en(second_port_pins_pu_en),
    .pad_hs_en(second_port_pins_hs_en)
  );

endmodule : iop_port_top
